// ===== inc/stepper_pkg.sv
// Shared constants, field layout and types for the microstep indexer and chopper
// -----------------------------------------------------------------------------
// Functional notes
// R1 - Every rising edge of the step pin advances the indexer by one table state.
// R2 - Writing 1 to the software step bit advances the indexer like a step edge; a write in the same cycle as a step pin edge gives one step, not two.
// R3 - Direction pin high with reverse 0, or low with reverse 1, steps angle upward.
// R4 - Direction pin low with reverse 0, or high with reverse 1, steps angle downward.
// R5 - After a resolution change, next step lands on next state valid for new resolution.
// R6 - Positive table current drives first winding terminal high against the second.
// R7 - Sensed current reaching threshold stops bridge drive for the programmed off period.
// R8 - Off period programmable by off-time field from 500 ns up to 128 us.
// R9 - When the off period expires the bridge drives again, starting a new cycle.
// R10 - Drive ends when sense voltage times amplifier gain reaches the reference.
// R11 - Reference is sine lookup output times current scale, full scale 2.75 V.
// R12 - Full-scale current is 2.75 V times scale over 256, gain and sense resistance.
// R13 - Sense amplifier gain is selectable as 5, 10, 20 or 40.
// R14 - Resolution code 0000 is full step, each code halves, 1000 is 1/256 step.
// R15 - First winding follows sine of electrical angle, second winding follows cosine.
// R16 - Power-up or reset puts the indexer in the 45 degree home state.
// R17 - Resolutions finer than 1/8 step follow the same sine pattern, finer increments.
// R18 - 1/8 step has 32 states per cycle; coarser use subsets; full step diagonals.
// R19 - Host keeps direction pin stable around each step rising edge.
// -----------------------------------------------------------------------------
package stepper_pkg;

  // Register map, byte addresses
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  SCALE_OFFSET  = 8'h04;
  localparam logic [7:0]  OFF_OFFSET    = 8'h08;
  localparam logic [7:0]  STATUS_OFFSET = 8'h0C;
  localparam logic [7:0]  REF_OFFSET    = 8'h10;

  // Control register fields
  localparam int          MODE_LSB      = 0;
  localparam int          REVERSE_BIT   = 4;
  localparam int          SW_STEP_BIT   = 5;
  localparam int          GAIN_LSB      = 6;
  localparam int          ENABLE_BIT    = 8;
  localparam logic [31:0] CTRL_WMASK    = 32'h0000_01DF;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0003;
  localparam logic [7:0]  SCALE_RESET   = 8'hFF;
  localparam logic [7:0]  OFF_RESET     = 8'h1F;

  // Indexer: 1024 states per electrical cycle at the finest resolution
  localparam int          ANGLE_W       = 10;
  localparam logic [3:0]  MODE_FINEST   = 4'h8;
  localparam logic [9:0]  HOME_ANGLE    = 10'h080;
  localparam logic [9:0]  QUARTER_TURN  = 10'h100;

  // Sense amplifier gains for codes 0..3
  localparam logic [5:0]  GAIN_5        = 6'h05;
  localparam logic [5:0]  GAIN_10       = 6'h0A;
  localparam logic [5:0]  GAIN_20       = 6'h14;
  localparam logic [5:0]  GAIN_40       = 6'h28;
  localparam int          SENSE_W       = 10;
  localparam int          REF_SHIFT     = 6;

  // Off time: (field + 1) units of 500 ns, up to 256 units = 128 us
  localparam int          CLK_MHZ       = 40;
  localparam int          OFF_UNIT_NS   = 500;
  localparam int          OFF_UNIT_CYC  = (OFF_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int          OFF_CNT_W     = 13;

  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef struct packed {
    logic first;
    logic second;
  } bridge_drive_s;

endpackage

// ===== sim/host_step_model.sv
// Host model driving the step and direction pins
`timescale 1ns/1ps
module host_step_model
(
  input  wire logic ref_clk,
  output logic      step_pin = 1'b0,
  output logic      dir_pin = 1'b0
);
  // Hold is the pulse width and gap, in cycles
  task automatic pulse(input logic up, input int hold);
    @(posedge ref_clk);
    dir_pin <= up;
    @(posedge ref_clk);
    step_pin <= 1'b1;
    repeat (hold) @(posedge ref_clk);
    step_pin <= 1'b0;
    repeat (hold) @(posedge ref_clk);
  endtask
endmodule

// ===== sim/microstep_indexer_current_ref_tb_top.sv
// Self-checking bench for the microstep indexer and chopping reference
`timescale 1ns/1ps
module microstep_indexer_current_ref_tb_top;
  import stepper_pkg::*;
  localparam int REF_HOME = (16'h00B4 * 16'h00FF) >> 6;
  localparam int OFF_N    = 4;
  logic          ref_clk = 1'b0;
  logic          rstn    = 1'b0;
  logic [7:0]    awaddr  = '0;
  logic [7:0]    araddr  = '0;
  logic [31:0]   wdata   = '0;
  logic          awvalid = 1'b0;
  logic          wvalid  = 1'b0;
  logic          bready  = 1'b0;
  logic          arvalid = 1'b0;
  logic          rready  = 1'b0;
  logic [9:0]    sense_a = '0;
  logic [9:0]    sense_b = '0;
  logic          awready, wready, bvalid, arready, rvalid, step_pin, dir_pin;
  logic [1:0]    bresp, rresp, r;
  logic [31:0]   rdata;
  bridge_drive_s win_a, win_b;
  logic [9:0]    ref_a, ref_b, angle;
  int            fails      = 0;
  int            n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;

  microstep_indexer_current_ref #(.OFF_UNIT_CYCLES(1)) u_microstep_indexer_current_ref (
    .ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .step_pin(step_pin), .dir_pin(dir_pin), .current_sense_a(sense_a),
    .current_sense_b(sense_b), .winding_a_output(win_a), .winding_b_output(win_b),
    .ref_a_code(ref_a), .ref_b_code(ref_b), .electrical_angle(angle));

  host_step_model u_host_step_model (.ref_clk(ref_clk), .step_pin(step_pin), .dir_pin(dir_pin));

  // ---------------------------------------------------------------
  // Bus and comparison tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Sampled at the falling edge, settled since the rise
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic aw_ok, w_ok, b_ok;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(negedge ref_clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      rs = bresp;
      @(posedge ref_clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) break;
    end
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    logic ar_ok, r_ok;
    logic [31:0] dd;
    logic [1:0]  rr;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(negedge ref_clk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      dd = rdata;
      rr = rresp;
      @(posedge ref_clk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) break;
    end
    rready <= 1'b0;
    check(dd, d, "rdata");
    check(32'(rr), 32'(rs), "rresp");
  endtask

  task automatic step_chk(input logic up, input int hold, input logic [9:0] exp);
    u_host_step_model.pulse(up, hold);
    settle(1);
    check(32'(angle), 32'(exp), "angle");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    settle(2);
    check(32'(angle), 32'(HOME_ANGLE), "home");
    check(32'(ref_a), REF_HOME, "ref a home");
    check(32'(ref_b), REF_HOME, "ref b home");
    rd_chk(CTRL_OFFSET, CTRL_RESET, RESP_OKAY);
    rd_chk(SCALE_OFFSET, 32'h0000_00FF, RESP_OKAY);
    rd_chk(OFF_OFFSET, 32'h0000_001F, RESP_OKAY);
    rd_chk(8'h14, 32'h0000_0000, RESP_SLVERR);
    axi_wr(STATUS_OFFSET, 32'h0000_0001, r);
    check(32'(r), 32'(RESP_SLVERR), "ro write");
    $display("test reset done");
  endtask

  task automatic t_ref();
    axi_wr(SCALE_OFFSET, 32'h0000_0080, r);
    settle(4);
    check(32'(ref_a), 32'h0000_0168, "scaled ref");
    axi_wr(SCALE_OFFSET, 32'h0000_00FF, r);
    settle(4);
    check(32'(ref_b), REF_HOME, "restored ref");
    $display("test ref done");
  endtask

  task automatic t_chop();
    logic [5:0] gains [4];
    int thr, za, zb;
    gains = '{GAIN_5, GAIN_10, GAIN_20, GAIN_40};
    axi_wr(OFF_OFFSET, 32'(OFF_N - 1), r);
    for (int g = 0; g < 4; g++)
    begin
      axi_wr(CTRL_OFFSET, 32'h0000_0103 | (g << 6), r);
      thr = (REF_HOME + int'(gains[g]) - 1) / int'(gains[g]);
      sense_a <= 10'(thr - 1);
      za = 0;
      repeat (8) begin @(negedge ref_clk); za += int'(win_a === 2'b00); end
      check(32'(za), 0, "early trip");
      @(posedge ref_clk);
      sense_a <= 10'(thr);
      sense_b <= 10'(thr);
      @(posedge ref_clk);
      sense_a <= '0;
      sense_b <= '0;
      za = 0;
      zb = 0;
      repeat (30) begin @(negedge ref_clk); za += int'(win_a === 2'b00); zb += int'(win_b === 2'b00); end
      check(32'(za), OFF_N, "off span a");
      check(32'(zb), OFF_N, "off span b");
    end
    $display("test chop done");
  endtask

  task automatic t_dir();
    axi_wr(CTRL_OFFSET, 32'h0000_0103, r);
    for (int i = 1; i <= 8; i++)
      step_chk(1'b1, 1, 10'(10'h080 + 32 * i));
    settle(3);
    check(32'(win_a), 32'h0000_0002, "a sign");
    check(32'(win_b), 32'h0000_0001, "b sign");
    axi_wr(CTRL_OFFSET, 32'h0000_0113, r);
    step_chk(1'b1, 76, 10'h160);
    step_chk(1'b0, 1, 10'h180);
    axi_wr(CTRL_OFFSET, 32'h0000_0103, r);
    step_chk(1'b0, 1, 10'h160);
    $display("test dir done");
  endtask

  task automatic t_sw();
    axi_wr(CTRL_OFFSET, 32'h0000_0123, r);
    settle(2);
    check(32'(angle), 32'h0000_0140, "sw step");
    rd_chk(CTRL_OFFSET, 32'h0000_0103, RESP_OKAY);
    $display("test sw done");
  endtask

  task automatic t_mode();
    axi_wr(CTRL_OFFSET, 32'h0000_0100, r);
    step_chk(1'b1, 1, 10'h180);
    for (int m = 0; m <= 8; m++)
    begin
      axi_wr(CTRL_OFFSET, 32'h0000_0100 | m, r);
      step_chk(1'b1, 1, 10'(10'h180 + (1 << (8 - m))));
      step_chk(1'b0, 1, 10'h180);
    end
    axi_wr(CTRL_OFFSET, 32'h0000_0103, r);
    step_chk(1'b1, 1, 10'h1A0);
    axi_wr(CTRL_OFFSET, 32'h0000_0100, r);
    step_chk(1'b0, 1, 10'h180);
    $display("test mode done");
  endtask

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_ref();
    t_chop();
    t_dir();
    t_sw();
    t_mode();
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end
endmodule

// ===== sim/stepper_chk_sva.sv
// Concurrent checks on the indexer, reference and bus ports
`timescale 1ns/1ps
module stepper_chk
  import stepper_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               rstn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               step_pin,
  input wire bridge_drive_s      winding_a_output,
  input wire bridge_drive_s      winding_b_output,
  input wire logic [SENSE_W-1:0] ref_a_code,
  input wire logic [ANGLE_W-1:0] electrical_angle
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking chk_clk @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  chk_home_reset: assert property ($rose(rstn) |-> electrical_angle == HOME_ANGLE)
    else $error("angle not at home after reset");
  // Software steps land beside bvalid
  chk_step_cause: assert property ($changed(electrical_angle) |->
    ($past(step_pin) && !$past(step_pin, 2)) || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("angle moved without a step");
  chk_ref_cause: assert property ($changed(ref_a_code) |-> !$past(rstn, 2) ||
    s_axi_bvalid || $past(s_axi_bvalid) || $past(electrical_angle) != $past(electrical_angle, 2))
    else $error("reference moved without cause");
  chk_no_shoot: assert property (winding_a_output != 2'b11 && winding_b_output != 2'b11)
    else $error("both bridge terminals driven");
  chk_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read data not retired");
endmodule

bind microstep_indexer_current_ref stepper_chk u_stepper_chk (.*);

// ===== src/microstep_indexer_current_ref.sv
// Microstep indexer, chopping reference and AXI4-Lite register file
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module microstep_indexer_current_ref
  import stepper_pkg::*;
#(
  parameter int OFF_UNIT_CYCLES = OFF_UNIT_CYC
)
(
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Host step and direction
  input  wire logic                step_pin,
  input  wire logic                dir_pin,
  // Digitised sense voltages, LSB = 2.75 V / 1024 before gain
  input  wire logic [SENSE_W-1:0]  current_sense_a,
  input  wire logic [SENSE_W-1:0]  current_sense_b,
  // Bridge drive and reference outputs
  output bridge_drive_s            winding_a_output,
  output bridge_drive_s            winding_b_output,
  output logic [SENSE_W-1:0]       ref_a_code,
  output logic [SENSE_W-1:0]       ref_b_code,
  output logic [ANGLE_W-1:0]       electrical_angle
);

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic [31:0]        ctrl_reg;
  logic [7:0]         scale_reg;
  logic [7:0]         off_reg;

  logic [3:0]         mode_field;
  logic               reverse_direction_bit;
  logic [1:0]         sense_amp_gain_field;
  logic               drive_enable;
  logic [7:0]         off_time_field;

  assign mode_field            = ctrl_reg[MODE_LSB +: 4];
  assign reverse_direction_bit = ctrl_reg[REVERSE_BIT];
  assign sense_amp_gain_field  = ctrl_reg[GAIN_LSB +: 2];
  assign drive_enable          = ctrl_reg[ENABLE_BIT];
  assign off_time_field        = off_reg;

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------------
  // Either order; each is held until both meet
  logic               aw_held;
  logic [ADDR_W-1:0]  aw_addr;
  logic               w_held;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               wr_fire;
  logic [31:0]        byte_mask;
  logic               wr_ctrl;
  logic               wr_scale;
  logic               wr_off;
  logic               wr_mapped;
  logic [31:0]        ctrl_merged;
  logic [31:0]        scale_merged;
  logic [31:0]        off_merged;
  logic               software_step_bit;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign byte_mask     = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wr_ctrl       = wr_fire && (aw_addr == CTRL_OFFSET);
  assign wr_scale      = wr_fire && (aw_addr == SCALE_OFFSET);
  assign wr_off        = wr_fire && (aw_addr == OFF_OFFSET);
  assign wr_mapped     = (aw_addr == CTRL_OFFSET) || (aw_addr == SCALE_OFFSET)
                      || (aw_addr == OFF_OFFSET);
  assign ctrl_merged   = ((ctrl_reg & ~byte_mask) | (w_data & byte_mask)) & CTRL_WMASK;
  assign scale_merged  = ({24'h0, scale_reg} & ~byte_mask) | (w_data & byte_mask);
  assign off_merged    = ({24'h0, off_reg} & ~byte_mask) | (w_data & byte_mask);
  // The step bit is a command, never stored
  assign software_step_bit = wr_ctrl && w_strb[0] && w_data[SW_STEP_BIT]; // R2

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg  <= CTRL_RESET;
      scale_reg <= SCALE_RESET;
      off_reg   <= OFF_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= ctrl_merged;
      if (wr_scale)
        scale_reg <= scale_merged[7:0];
      if (wr_off)
        off_reg <= off_merged[7:0]; // R8
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------------
  logic [31:0]        read_value;
  logic               read_mapped;
  logic [1:0]         bridge_state;

  assign s_axi_arready = !s_axi_rvalid;
  assign read_mapped   = (s_axi_araddr == CTRL_OFFSET) || (s_axi_araddr == SCALE_OFFSET)
                      || (s_axi_araddr == OFF_OFFSET) || (s_axi_araddr == STATUS_OFFSET)
                      || (s_axi_araddr == REF_OFFSET);
  assign read_value    =
      (s_axi_araddr == CTRL_OFFSET)   ? ctrl_reg :
      (s_axi_araddr == SCALE_OFFSET)  ? {24'h0, scale_reg} :
      (s_axi_araddr == OFF_OFFSET)    ? {24'h0, off_reg} :
      (s_axi_araddr == STATUS_OFFSET) ? {14'h0, bridge_state, 6'h00, electrical_angle} :
      (s_axi_araddr == REF_OFFSET)    ? {6'h00, ref_b_code, 6'h00, ref_a_code} :
                                        32'h0000_0000;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_value;
      s_axi_rresp  <= read_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Step indexer
  // ---------------------------------------------------------------------------
  logic               step_prev;
  logic               step_event;
  logic               step_up;
  logic [3:0]         mode_eff;
  logic [ANGLE_W-1:0] step_inc;
  logic [ANGLE_W-1:0] grid_mask;
  logic [ANGLE_W-1:0] grid_offset;
  logic [ANGLE_W-1:0] rel_angle;
  logic [ANGLE_W-1:0] grid_base;
  logic               on_grid;
  logic [ANGLE_W-1:0] next_rel;
  logic [ANGLE_W-1:0] next_angle;

  // Direction is sampled with the step edge
  assign step_event  = (step_pin && !step_prev) || software_step_bit; // R1 R2 R19
  assign step_up     = dir_pin ^ reverse_direction_bit; // R3 R4
  // Codes above 1/256 step act as 1/256 step
  assign mode_eff    = (mode_field > MODE_FINEST) ? MODE_FINEST : mode_field; // R14
  assign step_inc    = ANGLE_W'(10'h001 << (MODE_FINEST - mode_eff)); // R17 R18
  assign grid_mask   = ANGLE_W'(step_inc - 1'b1);
  // Full step rides the 45 degree diagonals
  assign grid_offset = (mode_eff == 4'h0) ? HOME_ANGLE : '0; // R18
  assign rel_angle   = ANGLE_W'(electrical_angle - grid_offset);
  assign grid_base   = rel_angle & ~grid_mask;
  assign on_grid     = (rel_angle & grid_mask) == '0;
  // Off grid after a mode change: snap toward the step
  assign next_rel    = step_up ? ANGLE_W'(grid_base + step_inc) :
                       on_grid ? ANGLE_W'(grid_base - step_inc) : grid_base; // R5 R3 R4
  assign next_angle  = ANGLE_W'(next_rel + grid_offset);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      step_prev        <= 1'b0;
      electrical_angle <= HOME_ANGLE; // R16
    end
    else
    begin
      step_prev <= step_pin;
      if (step_event)
        electrical_angle <= next_angle; // R1
    end
  end

  // ---------------------------------------------------------------------------
  // Chopping reference and current regulation per winding
  // ---------------------------------------------------------------------------
  logic [5:0]           gain_factor;
  logic [OFF_CNT_W-1:0] off_cycles;
  logic [ANGLE_W-1:0]   winding_angle [0:1];
  logic [SENSE_W-1:0]   sense_in      [0:1];
  logic [SENSE_W-1:0]   ref_code      [0:1];
  bridge_drive_s        drive         [0:1];

  assign gain_factor = (sense_amp_gain_field == 2'd0) ? GAIN_5  :
                       (sense_amp_gain_field == 2'd1) ? GAIN_10 :
                       (sense_amp_gain_field == 2'd2) ? GAIN_20 : GAIN_40; // R13
  assign off_cycles  = OFF_CNT_W'((off_time_field + 9'h001) * OFF_UNIT_CYCLES); // R8
  // Quarter-turn lead gives the cosine
  assign winding_angle[0] = electrical_angle; // R15
  assign winding_angle[1] = ANGLE_W'(electrical_angle + QUARTER_TURN); // R15
  assign sense_in[0]      = current_sense_a;
  assign sense_in[1]      = current_sense_b;

  generate
    for (genvar w = 0; w < 2; w++)
    begin : g_winding
      logic [7:0]          magnitude;
      logic                negative;
      logic [15:0]         ref_product;
      logic [SENSE_W-1:0]  next_ref;
      logic [15:0]         amplified;
      logic                trip;
      logic                bridge_on;

      sine_lookup u_sine (
        .angle     (winding_angle[w]),
        .magnitude (magnitude),
        .negative  (negative)
      );

      // Full scale of 255 x 255 maps onto the 2.75 V reference range
      assign ref_product = 16'(magnitude * scale_reg); // R11 R12
      assign next_ref    = ref_product[REF_SHIFT +: SENSE_W]; // R11
      assign amplified   = 16'(sense_in[w] * gain_factor); // R10 R13
      assign trip        = amplified >= {6'h00, ref_code[w]}; // R10

      off_time_chopper u_chop (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .enable     (drive_enable),
        .trip       (trip),
        .off_cycles (off_cycles),
        .bridge_on  (bridge_on)
      );

      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          ref_code[w] <= '0;
          drive[w]    <= '0;
        end
        else
        begin
          ref_code[w]     <= next_ref;
          drive[w].first  <= bridge_on && !negative; // R6 R7 R9
          drive[w].second <= bridge_on && negative; // R6
        end
      end
    end
  endgenerate

  assign bridge_state     = {g_winding[1].bridge_on, g_winding[0].bridge_on};
  assign ref_a_code       = ref_code[0];
  assign ref_b_code       = ref_code[1];
  assign winding_a_output = drive[0];
  assign winding_b_output = drive[1];

endmodule

// ===== src/off_time_chopper.sv
// Fixed off-time current chopper for one bridge
`timescale 1ns/1ps
module off_time_chopper
  import stepper_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 enable,
  input  wire logic                 trip,
  input  wire logic [OFF_CNT_W-1:0] off_cycles,
  output logic                      bridge_on
);

  typedef enum logic {DRIVE, OFF_TIME} chop_state_e;

  chop_state_e          state;
  chop_state_e          next_state;
  logic [OFF_CNT_W-1:0] count;
  logic [OFF_CNT_W-1:0] next_count;

  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      DRIVE:
      begin
        if (enable && trip)
        begin
          next_state = OFF_TIME; // R7
          next_count = OFF_CNT_W'(off_cycles - 1'b1);
        end
      end
      OFF_TIME:
      begin
        if (count == '0)
          next_state = DRIVE; // R9
        else
          next_count = OFF_CNT_W'(count - 1'b1);
      end
      default: next_state = DRIVE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= DRIVE;
      count <= '0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign bridge_on = enable && (state == DRIVE);

endmodule

// ===== src/sine_lookup.sv
// Interpolated sine magnitude and sign for a 10-bit electrical angle
`timescale 1ns/1ps
module sine_lookup
  import stepper_pkg::*;
(
  input  wire logic [ANGLE_W-1:0] angle,
  output logic      [7:0]         magnitude,
  output logic                    negative
);

  // 1/8-step points of one quarter wave, full scale 255
  logic [7:0]  points [0:8];
  assign points[0] = 8'h00;
  assign points[1] = 8'h32;
  assign points[2] = 8'h62;
  assign points[3] = 8'h8E;
  assign points[4] = 8'hB4;
  assign points[5] = 8'hD4;
  assign points[6] = 8'hEC;
  assign points[7] = 8'hFA;
  assign points[8] = 8'hFF;

  logic [8:0]  pos;
  logic [3:0]  seg;
  logic [3:0]  seg_hi;
  logic [4:0]  frac;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic [12:0] step_part;

  // Finer modes walk between the 1/8-step points linearly
  assign pos       = angle[8] ? 9'(9'h100 - {1'b0, angle[7:0]}) : {1'b0, angle[7:0]}; // R17
  assign seg       = pos[8:5];
  assign seg_hi    = (seg == 4'h8) ? 4'h8 : 4'(seg + 4'h1);
  assign frac      = pos[4:0];
  assign lo        = points[seg];
  assign hi        = points[seg_hi];
  assign step_part = 13'(8'(hi - lo) * frac);
  assign magnitude = 8'(lo + step_part[12:5]);
  assign negative  = angle[9] && (magnitude != 8'h00);

endmodule
